//--- rtl/ctu_map.svh
// Register offsets, field positions, reset values and counts of the timer unit
// Assumes an 8-bit internal data bus with a byte address
`ifndef CTU_MAP_SVH
`define CTU_MAP_SVH

`define CTU_OFS_FLAGS 8'h08
`define CTU_OFS_IRQ_EN 8'h09
`define CTU_OFS_CTRL_ONE 8'h0A
`define CTU_OFS_CTRL_TWO 8'h0B
`define CTU_OFS_TA_STATUS 8'h0C
`define CTU_OFS_CNT_BASE 8'h20

`define CTU_CTRL_ONE_RESET 8'h00
`define CTU_CTRL_ONE_MASK 8'h4F
`define CTU_CTRL_TWO_RESET 8'h00
`define CTU_CTRL_TWO_MASK 8'h3F
`define CTU_IRQ_EN_RESET 8'h00
`define CTU_IRQ_EN_MASK 8'h30
`define CTU_BYTE_ZERO 8'h00
`define CTU_BYTE_ONE 8'h01

`define CTU_BIT_MON_LOAD 0
`define CTU_BIT_TA_IRQ_EN 6
`define CTU_BIT_T1_RUN 0
`define CTU_BIT_T1_SRC 1
`define CTU_BIT_T1_PRESC 2
`define CTU_BIT_T2_RUN 3
`define CTU_BIT_T2_SRC 4
`define CTU_BIT_T2_PRESC 5
`define CTU_BIT_T1_FLAG 4
`define CTU_BIT_T2_FLAG 5
`define CTU_BIT_TA_FLAG 0

`define CTU_IDX_T1 0
`define CTU_IDX_T2 1
`define CTU_IDX_TA 2
`define CTU_IDX_TM 3
`define CTU_NUM_TIMERS 4

`define CTU_RESET_PULSE_CYCLES 2'd2
`define CTU_PULSE_CNT_ZERO 2'd0
`define CTU_PULSE_CNT_STEP 2'd1

`endif

//--- rtl/ctu_pkg.sv
// Types shared by the cascaded timer unit
// Constants live in ctu_map.svh
package ctu_pkg;
	typedef logic [7:0] ctu_byte_type;
	typedef enum logic [2:0]
	{
		MON_IDLE = 3'b001,
		MON_ARMED = 3'b010,
		MON_PULSE = 3'b100
	} ctu_mon_state_type;
endpackage

//--- rtl/ctu_timer_channel.sv
// One timer: low and high down-counters with their reload latches
// Assumes single-cycle tick, write and reload pulses from the unit
`timescale 1ns/1ps
`include "ctu_map.svh"
module ctu_timer_channel #(
	parameter bit RELOAD_ON_HIGH = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic fall_tick_i,
	input wire logic rise_tick_i,
	input wire logic prescale_i,
	input wire logic wr_low_i,
	input wire logic wr_high_i,
	input wire logic reload_i,
	input wire ctu_pkg::ctu_byte_type wr_data_i,
	output ctu_pkg::ctu_byte_type low_cnt_o,
	output ctu_pkg::ctu_byte_type high_cnt_o,
	output logic timeout_o
);
	import ctu_pkg::*;

	ctu_byte_type low_latch;
	ctu_byte_type high_latch;
	ctu_byte_type next_low_latch;
	ctu_byte_type next_high_latch;
	ctu_byte_type next_low_cnt;
	ctu_byte_type next_high_cnt;
	logic next_timeout;
	logic expire;

	assign expire = rise_tick_i && (high_cnt_o == `CTU_BYTE_ZERO);

	always_comb
	begin
		next_low_latch = low_latch;
		next_high_latch = high_latch;
		next_low_cnt = low_cnt_o;
		next_high_cnt = high_cnt_o;
		next_timeout = 1'b0;
		if (wr_low_i)
			next_low_latch = wr_data_i; // RULE4
		if (wr_high_i)
		begin
			next_high_latch = wr_data_i;
			if (RELOAD_ON_HIGH)
			begin
				next_high_cnt = wr_data_i; // RULE10
				next_low_cnt = low_latch; // RULE10
			end
		end
		else if (reload_i)
		begin
			next_high_cnt = high_latch;
			next_low_cnt = low_latch;
		end
		else if (expire)
		begin
			next_timeout = 1'b1; // RULE7
			next_high_cnt = high_latch; // RULE9
			next_low_cnt = low_latch; // RULE9
		end
		else if (fall_tick_i)
		begin
			if (low_cnt_o == `CTU_BYTE_ZERO)
			begin
				next_high_cnt = high_cnt_o - `CTU_BYTE_ONE; // RULE6
				if (prescale_i)
					next_low_cnt = low_latch; // RULE2
				else
					next_low_cnt = low_cnt_o - `CTU_BYTE_ONE; // RULE1
			end
			else
				next_low_cnt = low_cnt_o - `CTU_BYTE_ONE; // RULE1
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			low_latch <= `CTU_BYTE_ZERO;
			high_latch <= `CTU_BYTE_ZERO;
			low_cnt_o <= `CTU_BYTE_ZERO;
			high_cnt_o <= `CTU_BYTE_ZERO;
			timeout_o <= 1'b0;
		end
		else
		begin
			low_latch <= next_low_latch;
			high_latch <= next_high_latch;
			low_cnt_o <= next_low_cnt;
			high_cnt_o <= next_high_cnt;
			timeout_o <= next_timeout;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence quiet_seq;
		!wr_low_i && !wr_high_i && !reload_i;
	endsequence

	chk_low_write_latch: assert property ( // RULE4
		wr_low_i && !wr_high_i && !reload_i && !fall_tick_i && !rise_tick_i
		|=> $stable(low_cnt_o) && low_latch == $past(wr_data_i))
		else $error("low write changed the running low counter");

	chk_low_decrement: assert property ( // RULE1
		quiet_seq and (fall_tick_i && !expire && low_cnt_o != `CTU_BYTE_ZERO)
		|=> low_cnt_o == $past(low_cnt_o) - `CTU_BYTE_ONE)
		else $error("low counter did not count down by one");

	chk_high_cascade: assert property ( // RULE6
		quiet_seq and (fall_tick_i && !expire && low_cnt_o == `CTU_BYTE_ZERO)
		|=> high_cnt_o == $past(high_cnt_o) - `CTU_BYTE_ONE)
		else $error("high counter did not step on low zero");

	chk_timeout_reload: assert property ( // RULE9
		quiet_seq and expire
		|=> timeout_o && low_cnt_o == $past(low_latch)
			&& high_cnt_o == $past(high_latch))
		else $error("timeout did not reload both counters");

	chk_high_write_reload: assert property ( // RULE10
		wr_high_i && RELOAD_ON_HIGH
		|=> high_cnt_o == $past(wr_data_i) && low_cnt_o == $past(low_latch)
			&& !timeout_o)
		else $error("high write did not reload the counters");
endmodule

//--- rtl/ctu_timer_unit.sv
// Cascaded timer unit: two general timers, timer A and the monitor timer
// Assumes single-cycle CPU strobes and a phase clock synchronous to sys_clk_i
//
// Behaviour
// RULE1 - Each timer-clock fall decrements the low counter
// RULE2 - Prescaler mode reloads low counter on a fall at low zero instead of wrapping
// RULE3 - Monitor timer always cascades, never prescales
// RULE4 - Low counter write only updates the low latch
// RULE5 - Counter reads return live counter values
// RULE6 - Timer-clock fall at low zero decrements high
// RULE7 - High zero on rise sets timer flags
// RULE8 - Monitor timeout pulls reset low two cycles
// RULE9 - Timeout reloads both counters from latches
// RULE10 - High write loads latch, reloads both counters except on the monitor timer
// RULE11 - Monitor idle until load bit first rises
// RULE12 - Load bit rise reloads monitor; fall ignored
// RULE13 - Control one bit six enables timer A interrupt
// RULE14 - Per-timer bit selects system or phase clock for the two general timers; timer A and monitor use phase
// RULE15 - Writing one pulses flag clear; zero ignored
// RULE16 - Timer A timeout raises gated interrupt request
`timescale 1ns/1ps
`include "ctu_map.svh"
module ctu_timer_unit (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] cpu_addr_i,
	input wire ctu_pkg::ctu_byte_type cpu_wdata_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_phase_clock_i,
	output ctu_pkg::ctu_byte_type cpu_rdata_o,
	output logic timer1_irq_o,
	output logic timer2_irq_o,
	output logic timer_a_irq_o,
	output logic chip_reset_pin_o,
	output logic chip_reset_pin_oe_o
);
	import ctu_pkg::*;

	localparam int NT = `CTU_NUM_TIMERS;

	logic rst_meta;
	logic rst_sync_n;
	logic phase_prev;
	logic phase_valid;
	logic phase_fall;
	logic phase_rise;

	ctu_byte_type ctrl_one;
	ctu_byte_type ctrl_two;
	ctu_byte_type irq_en;
	ctu_byte_type next_ctrl_one;
	ctu_byte_type next_ctrl_two;
	ctu_byte_type next_irq_en;
	logic t1_flag;
	logic t2_flag;
	logic ta_flag;
	logic next_t1_flag;
	logic next_t2_flag;
	logic next_ta_flag;
	logic next_t1_irq;
	logic next_t2_irq;
	logic next_ta_irq;
	ctu_byte_type next_rdata;
	logic mon_rise;

	ctu_mon_state_type mon_state;
	ctu_mon_state_type next_mon_state;
	logic [1:0] pulse_cnt;
	logic [1:0] next_pulse_cnt;

	logic [NT-1:0] src_clk;
	logic [NT-1:0] run;
	logic [NT-1:0] prescale;
	logic [NT-1:0] reload;
	logic [NT-1:0] timeout;
	ctu_byte_type low_cnt [NT];
	ctu_byte_type high_cnt [NT];

	// Reset release through two flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{rst_sync_n, rst_meta} <= 2'b00;
		else
			{rst_sync_n, rst_meta} <= {rst_meta, 1'b1};
	end

	// Phase clock edges, none until a first sample is held
	always_ff @(posedge sys_clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			{phase_valid, phase_prev} <= 2'b00;
		else
			{phase_valid, phase_prev} <= {1'b1, cpu_phase_clock_i};
	end

	assign phase_fall = phase_valid && phase_prev && !cpu_phase_clock_i;
	assign phase_rise = phase_valid && !phase_prev && cpu_phase_clock_i;

	// Per-timer configuration
	assign src_clk[`CTU_IDX_T1] = ctrl_two[`CTU_BIT_T1_SRC]; // RULE14
	assign src_clk[`CTU_IDX_T2] = ctrl_two[`CTU_BIT_T2_SRC]; // RULE14
	assign src_clk[`CTU_IDX_TA] = 1'b0;
	assign src_clk[`CTU_IDX_TM] = 1'b0;
	assign run[`CTU_IDX_T1] = ctrl_two[`CTU_BIT_T1_RUN];
	assign run[`CTU_IDX_T2] = ctrl_two[`CTU_BIT_T2_RUN];
	assign run[`CTU_IDX_TA] = 1'b1;
	assign run[`CTU_IDX_TM] = (mon_state == MON_ARMED); // RULE11
	assign prescale[`CTU_IDX_T1] = ctrl_two[`CTU_BIT_T1_PRESC]; // RULE2
	assign prescale[`CTU_IDX_T2] = ctrl_two[`CTU_BIT_T2_PRESC]; // RULE2
	assign prescale[`CTU_IDX_TA] = 1'b0;
	assign prescale[`CTU_IDX_TM] = 1'b0; // RULE3
	assign reload[`CTU_IDX_T1] = 1'b0;
	assign reload[`CTU_IDX_T2] = 1'b0;
	assign reload[`CTU_IDX_TA] = 1'b0;
	assign reload[`CTU_IDX_TM] = mon_rise; // RULE12

	// Load bit edge from a write to control one
	assign mon_rise = cpu_wr_i && (cpu_addr_i == `CTU_OFS_CTRL_ONE)
		&& cpu_wdata_i[`CTU_BIT_MON_LOAD] && !ctrl_one[`CTU_BIT_MON_LOAD];

	genvar i;
	generate
		for (i = 0; i < NT; i++)
		begin : g_timer
			logic tick_fall;
			logic tick_rise;
			logic wr_low;
			logic wr_high;
			assign tick_fall = run[i] && (src_clk[i] || phase_fall);
			assign tick_rise = run[i] && (src_clk[i] || phase_rise);
			assign wr_low = cpu_wr_i
				&& (cpu_addr_i == `CTU_OFS_CNT_BASE + 8'(2 * i));
			assign wr_high = cpu_wr_i
				&& (cpu_addr_i == `CTU_OFS_CNT_BASE + 8'(2 * i + 1));
			ctu_timer_channel #(
				.RELOAD_ON_HIGH(i != `CTU_IDX_TM)
			) u_chan (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_sync_n),
				.fall_tick_i(tick_fall),
				.rise_tick_i(tick_rise),
				.prescale_i(prescale[i]),
				.wr_low_i(wr_low),
				.wr_high_i(wr_high),
				.reload_i(reload[i]),
				.wr_data_i(cpu_wdata_i),
				.low_cnt_o(low_cnt[i]),
				.high_cnt_o(high_cnt[i]),
				.timeout_o(timeout[i])
			);
		end
	endgenerate

	// Registers, flags, read port
	always_comb
	begin
		logic clr_flags;
		logic clr_ta;
		clr_flags = cpu_wr_i && (cpu_addr_i == `CTU_OFS_FLAGS);
		clr_ta = cpu_wr_i && (cpu_addr_i == `CTU_OFS_TA_STATUS);
		next_ctrl_one = ctrl_one;
		next_ctrl_two = ctrl_two;
		next_irq_en = irq_en;
		next_rdata = cpu_rdata_o;
		if (cpu_wr_i)
		begin
			unique case (cpu_addr_i)
				`CTU_OFS_CTRL_ONE:
					next_ctrl_one = cpu_wdata_i & `CTU_CTRL_ONE_MASK;
				`CTU_OFS_CTRL_TWO:
					next_ctrl_two = cpu_wdata_i & `CTU_CTRL_TWO_MASK;
				`CTU_OFS_IRQ_EN:
					next_irq_en = cpu_wdata_i & `CTU_IRQ_EN_MASK;
				default:
					next_irq_en = irq_en;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_t1_flag = (t1_flag && !(clr_flags
			&& cpu_wdata_i[`CTU_BIT_T1_FLAG])) || timeout[`CTU_IDX_T1]; // RULE15
		next_t2_flag = (t2_flag && !(clr_flags
			&& cpu_wdata_i[`CTU_BIT_T2_FLAG])) || timeout[`CTU_IDX_T2]; // RULE15
		next_ta_flag = (ta_flag && !(clr_ta
			&& cpu_wdata_i[`CTU_BIT_TA_FLAG])) || timeout[`CTU_IDX_TA]; // RULE16
		next_t1_irq = next_t1_flag && next_irq_en[`CTU_BIT_T1_FLAG]; // RULE7
		next_t2_irq = next_t2_flag && next_irq_en[`CTU_BIT_T2_FLAG]; // RULE7
		next_ta_irq = next_ta_flag
			&& next_ctrl_one[`CTU_BIT_TA_IRQ_EN]; // RULE13
		if (cpu_rd_i)
		begin
			next_rdata = `CTU_BYTE_ZERO;
			unique case (cpu_addr_i)
				`CTU_OFS_CTRL_ONE: next_rdata = ctrl_one;
				`CTU_OFS_CTRL_TWO: next_rdata = ctrl_two;
				`CTU_OFS_IRQ_EN: next_rdata = irq_en;
				`CTU_OFS_FLAGS:
				begin
					next_rdata[`CTU_BIT_T1_FLAG] = t1_flag;
					next_rdata[`CTU_BIT_T2_FLAG] = t2_flag;
				end
				`CTU_OFS_TA_STATUS: next_rdata[`CTU_BIT_TA_FLAG] = ta_flag;
				default:
				begin
					for (int k = 0; k < NT; k++)
					begin
						if (cpu_addr_i == `CTU_OFS_CNT_BASE + 8'(2 * k))
							next_rdata = low_cnt[k]; // RULE5
						if (cpu_addr_i == `CTU_OFS_CNT_BASE + 8'(2 * k + 1))
							next_rdata = high_cnt[k]; // RULE5
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl_one <= `CTU_CTRL_ONE_RESET;
			ctrl_two <= `CTU_CTRL_TWO_RESET;
			irq_en <= `CTU_IRQ_EN_RESET;
			t1_flag <= 1'b0;
			t2_flag <= 1'b0;
			ta_flag <= 1'b0;
			timer1_irq_o <= 1'b0;
			timer2_irq_o <= 1'b0;
			timer_a_irq_o <= 1'b0;
			cpu_rdata_o <= `CTU_BYTE_ZERO;
		end
		else
		begin
			ctrl_one <= next_ctrl_one;
			ctrl_two <= next_ctrl_two;
			irq_en <= next_irq_en;
			t1_flag <= next_t1_flag;
			t2_flag <= next_t2_flag;
			ta_flag <= next_ta_flag;
			timer1_irq_o <= next_t1_irq;
			timer2_irq_o <= next_t2_irq;
			timer_a_irq_o <= next_ta_irq;
			cpu_rdata_o <= next_rdata;
		end
	end

	// Monitor timer arming and restart pulse
	always_comb
	begin
		next_mon_state = mon_state;
		next_pulse_cnt = pulse_cnt;
		unique case (mon_state)
			MON_IDLE:
				if (mon_rise)
					next_mon_state = MON_ARMED; // RULE11
			MON_ARMED:
				if (timeout[`CTU_IDX_TM])
				begin
					next_mon_state = MON_PULSE; // RULE8
					next_pulse_cnt = `CTU_PULSE_CNT_ZERO;
				end
			MON_PULSE:
			begin
				next_pulse_cnt = pulse_cnt + `CTU_PULSE_CNT_STEP;
				if (pulse_cnt == `CTU_RESET_PULSE_CYCLES
					- `CTU_PULSE_CNT_STEP)
					next_mon_state = MON_IDLE; // RULE8
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			mon_state <= MON_IDLE;
			pulse_cnt <= `CTU_PULSE_CNT_ZERO;
			chip_reset_pin_o <= 1'b0;
			chip_reset_pin_oe_o <= 1'b0;
		end
		else
		begin
			mon_state <= next_mon_state;
			pulse_cnt <= next_pulse_cnt;
			chip_reset_pin_o <= 1'b0;
			chip_reset_pin_oe_o <= (next_mon_state == MON_PULSE); // RULE8
		end
	end

	sequence mon_expire_seq;
		mon_state == MON_ARMED && timeout[`CTU_IDX_TM];
	endsequence
	sequence reset_drive_seq;
		chip_reset_pin_oe_o [*2] ##1 !chip_reset_pin_oe_o;
	endsequence

	chk_reset_pulse_two: assert property ( // RULE8
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		mon_expire_seq |=> reset_drive_seq)
		else $error("restart pulse is not two cycles long");
	chk_monitor_idle: assert property ( // RULE11
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		mon_state == MON_IDLE |-> !g_timer[`CTU_IDX_TM].tick_fall
			&& !timeout[`CTU_IDX_TM])
		else $error("monitor timer ran before being armed");
	chk_monitor_arm: assert property ( // RULE12
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		mon_rise && mon_state == MON_IDLE |=> mon_state == MON_ARMED)
		else $error("load bit rise did not arm the monitor");
	chk_flag_set_t1: assert property ( // RULE7
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		timeout[`CTU_IDX_T1] |=> t1_flag
			&& (timer1_irq_o == irq_en[`CTU_BIT_T1_FLAG]))
		else $error("timer one timeout did not set its flag");
	chk_flag_clear_one: assert property ( // RULE15
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		cpu_wr_i && cpu_addr_i == `CTU_OFS_FLAGS
			&& cpu_wdata_i[`CTU_BIT_T2_FLAG] && !timeout[`CTU_IDX_T2]
		|=> !t2_flag ##1 (t2_flag || !$past(timeout[`CTU_IDX_T2])))
		else $error("flag clear by writing one failed");
	chk_flag_write_zero: assert property ( // RULE15
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		cpu_wr_i && cpu_addr_i == `CTU_OFS_FLAGS
			&& !cpu_wdata_i[`CTU_BIT_T1_FLAG] && t1_flag
		|=> t1_flag)
		else $error("writing zero changed a flag");
	chk_ta_irq_gate: assert property ( // RULE13
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		!ctrl_one[`CTU_BIT_TA_IRQ_EN] |-> !timer_a_irq_o)
		else $error("timer A interrupt while disabled");
	chk_ta_irq_raise: assert property ( // RULE16
		@(posedge sys_clk_i) disable iff (!rst_sync_n)
		timeout[`CTU_IDX_TA] && ctrl_one[`CTU_BIT_TA_IRQ_EN]
			&& !(cpu_wr_i && cpu_addr_i == `CTU_OFS_CTRL_ONE)
		|=> timer_a_irq_o && ta_flag)
		else $error("timer A timeout raised no request");
endmodule

//--- verification/test_ctu_timer_unit.sv
// Self-checking bench for the cascaded timer unit
// Drives the CPU strobes and the phase clock directly, inputs change on falls
`timescale 1ns/1ps
`include "ctu_map.svh"
module test_ctu_timer_unit;
	import ctu_pkg::*;
	logic sys_clk_i;
	logic rst_n_i;
	logic [7:0] cpu_addr_i;
	ctu_byte_type cpu_wdata_i;
	logic cpu_wr_i;
	logic cpu_rd_i;
	logic cpu_phase_clock_i;
	ctu_byte_type cpu_rdata_o;
	logic timer1_irq_o;
	logic timer2_irq_o;
	logic timer_a_irq_o;
	logic chip_reset_pin_o;
	logic chip_reset_pin_oe_o;
	int miscompares;
	int tests_run;
	int oe_cnt = 0;
	ctu_byte_type rv;

	ctu_timer_unit dut_u (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.cpu_addr_i(cpu_addr_i),
		.cpu_wdata_i(cpu_wdata_i),
		.cpu_wr_i(cpu_wr_i),
		.cpu_rd_i(cpu_rd_i),
		.cpu_phase_clock_i(cpu_phase_clock_i),
		.cpu_rdata_o(cpu_rdata_o),
		.timer1_irq_o(timer1_irq_o),
		.timer2_irq_o(timer2_irq_o),
		.timer_a_irq_o(timer_a_irq_o),
		.chip_reset_pin_o(chip_reset_pin_o),
		.chip_reset_pin_oe_o(chip_reset_pin_oe_o)
	);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Length of the reset pull, counted in system clocks
	always @(posedge sys_clk_i)
		if (chip_reset_pin_oe_o === 1'b1)
			oe_cnt <= oe_cnt + 1;

	task automatic check(input string name, input logic [7:0] exp,
		input logic [7:0] seen);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		cpu_addr_i = a;
		cpu_wdata_i = d;
		cpu_wr_i = 1'b1;
		@(negedge sys_clk_i);
		cpu_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge sys_clk_i);
		cpu_addr_i = a;
		cpu_rd_i = 1'b1;
		@(negedge sys_clk_i);
		cpu_rd_i = 1'b0;
		@(negedge sys_clk_i);
		rv = cpu_rdata_o;
	endtask

	task automatic phase(input logic v);
		@(negedge sys_clk_i);
		cpu_phase_clock_i = v;
		repeat (5) @(negedge sys_clk_i);
	endtask

	task automatic sc_registers();
		rd(8'h0A); check("ctrl_one reset", 8'h00, rv);
		rd(8'h0B); check("ctrl_two reset", 8'h00, rv);
		rd(8'h30); check("unmapped read", 8'h00, rv);
		wr(8'h0A, 8'hFE);
		rd(8'h0A); check("ctrl_one bits", 8'h4E, rv);
		wr(8'h0A, 8'h00);
	endtask

	task automatic sc_timer_one_sys();
		int n;
		wr(8'h20, 8'h03);
		wr(8'h21, 8'h00);
		rd(8'h20); check("t1 low after high write", 8'h03, rv);
		wr(8'h20, 8'h07);
		rd(8'h20); check("t1 low after low write", 8'h03, rv);
		wr(8'h09, 8'h10);
		wr(8'h0B, 8'h03);
		n = 0;
		while (timer1_irq_o !== 1'b1 && n < 20)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		check("t1 irq", 8'h01, {7'h00, timer1_irq_o});
		wr(8'h0B, 8'h00);
		rd(8'h20); check("t1 low reloaded", 8'h07, rv);
		wr(8'h08, 8'h00);
		rd(8'h08); check("flag after zero write", 8'h10, rv);
		wr(8'h08, 8'h10);
		rd(8'h08); check("flag after one write", 8'h00, rv);
		check("t1 irq cleared", 8'h00, {7'h00, timer1_irq_o});
	endtask

	task automatic sc_timer_two_phase();
		wr(8'h24, 8'h01);
		wr(8'h25, 8'h00);
		wr(8'h22, 8'h02);
		wr(8'h23, 8'h01);
		wr(8'h0B, 8'h08);
		phase(1'b0);
		rd(8'h22); check("t2 low dec", 8'h01, rv);
		phase(1'b1);
		check("ta irq gated", 8'h00, {7'h00, timer_a_irq_o});
		rd(8'h0C); check("ta flag", 8'h01, rv);
		phase(1'b0);
		phase(1'b1);
		phase(1'b0);
		rd(8'h23); check("t2 high dec", 8'h00, rv);
		rd(8'h22); check("t2 low wrap", 8'hFF, rv);
		rd(8'h08); check("t2 flag early", 8'h00, rv);
		phase(1'b1);
		rd(8'h22); check("t2 low reload", 8'h02, rv);
		rd(8'h23); check("t2 high reload", 8'h01, rv);
		rd(8'h08); check("t2 flag", 8'h20, rv);
		check("t2 irq masked", 8'h00, {7'h00, timer2_irq_o});
		wr(8'h09, 8'h20);
		repeat (3) @(negedge sys_clk_i);
		check("t2 irq", 8'h01, {7'h00, timer2_irq_o});
		wr(8'h0A, 8'h40);
		repeat (3) @(negedge sys_clk_i);
		check("ta irq", 8'h01, {7'h00, timer_a_irq_o});
		wr(8'h0C, 8'h01);
		repeat (3) @(negedge sys_clk_i);
		check("ta irq cleared", 8'h00, {7'h00, timer_a_irq_o});
		wr(8'h0A, 8'h00);
		wr(8'h0B, 8'h00);
		wr(8'h08, 8'h20);
		check("monitor idle", 8'h00, 8'(oe_cnt));
	endtask

	task automatic sc_prescale();
		wr(8'h20, 8'h01);
		wr(8'h21, 8'h02);
		wr(8'h0B, 8'h05);
		phase(1'b0);
		phase(1'b1);
		phase(1'b0);
		rd(8'h20); check("t1 prescale low", 8'h01, rv);
		rd(8'h21); check("t1 prescale high", 8'h01, rv);
		wr(8'h0B, 8'h00);
	endtask

	task automatic sc_monitor();
		phase(1'b1);
		wr(8'h26, 8'h01);
		wr(8'h27, 8'h00);
		wr(8'h0A, 8'h01);
		rd(8'h26); check("tm low armed", 8'h01, rv);
		phase(1'b0);
		rd(8'h26); check("tm low dec", 8'h00, rv);
		wr(8'h0A, 8'h00);
		rd(8'h26); check("tm load bit fall", 8'h00, rv);
		check("no pull yet", 8'h00, 8'(oe_cnt));
		phase(1'b1);
		repeat (6) @(negedge sys_clk_i);
		check("reset pull length", 8'h02, 8'(oe_cnt));
		check("reset drive", 8'h00, {7'h00, chip_reset_pin_o});
		phase(1'b0);
		phase(1'b1);
		rd(8'h26); check("tm idle after pull", 8'h01, rv);
		check("single pull", 8'h02, 8'(oe_cnt));
	endtask

	initial
	begin
		rst_n_i = 1'b0;
		cpu_addr_i = 8'h00;
		cpu_wdata_i = 8'h00;
		cpu_wr_i = 1'b0;
		cpu_rd_i = 1'b0;
		cpu_phase_clock_i = 1'b1;
		miscompares = 0;
		tests_run = 0;
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		sc_registers();
		sc_timer_one_sys();
		sc_timer_two_phase();
		sc_prescale();
		sc_monitor();
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		miscompares++;
		final_report();
	end
endmodule
